// file: core/dp_register_map.sv
`timescale 1ns/1ps
// Debug port register map, architecture versions 1 and 2
// Behaviour
// - Selection register written only at address 0x8
// - Selection: port, port bank, debug port bank
// - Bank 0 at 0x4 is control/status
// - Link status bits: read-only serial, zero scan
// - Latched flags: read-only serial, write-one-clear scan
// - Bank 1 at 0x4 is link control, serial only
// - Serial: abort at 0x0, resend at 0x8
// - Version 2 widens debug port bank
// - Version 2 banks 2,3 give identification
// - Both versions: selection write at 0x8, buffer read at 0xC
// - Address 0 reads ID regardless of bank
// - ID version field reads architecture version
// - ID revision, part and designer field layout
// - ID minimal bit reflects configuration
module dp_register_map #(
	parameter logic [3:0] arch_version = dp_map_pkg::arch_v2,
	parameter bit serial_variant = 1'b1,
	parameter bit minimal_config = 1'b1,
	parameter logic [3:0] revision = 4'h0,
	parameter logic [7:0] part_number_field = 8'h00,
	parameter logic [10:0] designer_code = 11'h000, // Arbitrary value
	parameter logic [31:0] target_identification = 32'h0000_0001, // Arbitrary value
	parameter logic [31:0] link_protocol_identification = 32'h0000_0001
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Debugger register access, decoded by the link layer
	input wire logic access,
	input wire logic write,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata_q,
	// Access port results from the port side
	input wire logic ap_read_done,
	input wire logic [31:0] ap_read_data,
	// Status events from the link and port side
	input wire logic write_data_error_flag,
	input wire logic read_success_flag,
	input wire logic err_event,
	input wire logic cmp_event,
	input wire logic orun_event,
	// Selection register fields for the access port side
	output logic [7:0] access_port_number,
	output logic [3:0] access_port_bank,
	output logic [3:0] debug_port_bank,
	// Abort and link control outputs
	output logic abort_write,
	output logic [31:0] abort_data_q,
	output logic [31:0] link_control_q
);
	logic [31:0] select_q;
	logic [31:0] select_d;
	logic [31:0] last_read_q;
	logic [31:0] last_read_d;
	logic [31:0] buffer_q;
	logic [31:0] buffer_d;
	logic [31:0] abort_d;
	logic [31:0] link_d;
	logic [31:0] rdata_d;
	logic [31:0] id_value;
	logic [31:0] ctrl_value;
	logic [31:0] bank_value;
	logic [31:0] read_value;
	logic [3:0] bank_now;
	logic wr_zero;
	logic wr_bank;
	logic wr_select;
	logic rd_en;
	logic wr_ctrl;
	logic wr_link;
	logic is_v2;
	logic err_q;
	logic cmp_q;
	logic orun_q;
	logic [2:0] w1c;

	initial begin
		if (arch_version != dp_map_pkg::arch_v1 && arch_version != dp_map_pkg::arch_v2) begin
			$error("arch_version must be 1 or 2");
		end
	end

	// Version and bank decode
	assign is_v2 = (arch_version == dp_map_pkg::arch_v2);
	assign bank_now = is_v2 ? select_q[3:0] : {3'b000, select_q[0]};
	assign wr_zero = access & write & (addr == dp_map_pkg::addr_zero);
	assign wr_bank = access & write & (addr == dp_map_pkg::addr_bank);
	assign wr_select = access & write & (addr == dp_map_pkg::addr_select);
	assign rd_en = access & ~write;
	assign wr_ctrl = wr_bank & (bank_now == dp_map_pkg::bank_ctrl);
	assign wr_link = wr_bank & (bank_now == dp_map_pkg::bank_link) & serial_variant;

	// Selection register keeps only defined fields
	assign select_d = wr_select ? (wdata & (is_v2 ? 32'hff00_00ff : 32'hff00_00f1))
		: select_q;
	assign access_port_number = select_q[dp_map_pkg::sel_port_lo +: 8];
	assign access_port_bank = select_q[dp_map_pkg::sel_apbank_lo +: 4];
	assign debug_port_bank = bank_now;

	// Scan variant clears latched flags by writing one
	assign w1c = (wr_ctrl & ~serial_variant) ? {wdata[dp_map_pkg::cs_err],
		wdata[dp_map_pkg::cs_cmp], wdata[dp_map_pkg::cs_orun]} : 3'b000;

	sticky_flag err_flag (
		.clk(clk),
		.rst(rst),
		.set(err_event),
		.clear(w1c[2]),
		.flag_q(err_q)
	);

	sticky_flag cmp_flag (
		.clk(clk),
		.rst(rst),
		.set(cmp_event & ~minimal_config),
		.clear(w1c[1]),
		.flag_q(cmp_q)
	);

	sticky_flag orun_flag (
		.clk(clk),
		.rst(rst),
		.set(orun_event),
		.clear(w1c[0]),
		.flag_q(orun_q)
	);

	// Control/status read value
	always_comb begin
		ctrl_value = 32'h0000_0000;
		ctrl_value[dp_map_pkg::cs_wderr] = serial_variant & write_data_error_flag;
		ctrl_value[dp_map_pkg::cs_rdok] = serial_variant & read_success_flag;
		ctrl_value[dp_map_pkg::cs_err] = err_q;
		ctrl_value[dp_map_pkg::cs_cmp] = cmp_q;
		ctrl_value[dp_map_pkg::cs_orun] = orun_q;
	end

	// Identification register value
	always_comb begin
		id_value = 32'h0000_0000;
		id_value[dp_map_pkg::id_rev_lo +: 4] = revision;
		id_value[dp_map_pkg::id_part_lo +: 8] = part_number_field;
		id_value[dp_map_pkg::id_min_bit] = minimal_config;
		id_value[dp_map_pkg::id_ver_lo +: 4] = arch_version;
		id_value[dp_map_pkg::id_des_lo +: 11] = designer_code;
		id_value[0] = 1'b1;
	end

	// Banked read selection at address 0x4
	always_comb begin
		bank_value = 32'h0000_0000;
		unique case (bank_now)
			dp_map_pkg::bank_ctrl: bank_value = ctrl_value;
			dp_map_pkg::bank_link: bank_value = serial_variant ? link_control_q : 32'h0;
			dp_map_pkg::bank_target: bank_value = is_v2 ? target_identification : 32'h0;
			dp_map_pkg::bank_proto: bank_value = is_v2 ? link_protocol_identification : 32'h0;
			default: bank_value = 32'h0000_0000;
		endcase
	end

	// Read selection by address
	always_comb begin
		read_value = 32'h0000_0000;
		unique case (addr)
			dp_map_pkg::addr_zero: read_value = id_value;
			dp_map_pkg::addr_bank: read_value = bank_value;
			dp_map_pkg::addr_select: read_value = serial_variant ? last_read_q : 32'h0;
			dp_map_pkg::addr_buffer: read_value = buffer_q;
			default: read_value = 32'h0000_0000;
		endcase
	end

	// Next values for data registers
	assign rdata_d = rd_en ? read_value : rdata_q;
	assign buffer_d = ap_read_done ? ap_read_data : buffer_q;
	assign last_read_d = (rd_en && addr != dp_map_pkg::addr_select) ? read_value : last_read_q;
	assign abort_d = (wr_zero & serial_variant) ? wdata : abort_data_q;
	assign link_d = wr_link ? wdata : link_control_q;
	assign abort_write = wr_zero & serial_variant;

	// Register storage
	always_ff @(posedge clk) begin
		if (rst) begin
			select_q <= 32'h0000_0000;
			rdata_q <= 32'h0000_0000;
			last_read_q <= 32'h0000_0000;
			buffer_q <= 32'h0000_0000;
			abort_data_q <= 32'h0000_0000;
			link_control_q <= dp_map_pkg::link_ctrl_reset;
		end else begin
			select_q <= select_d;
			rdata_q <= rdata_d;
			last_read_q <= last_read_d;
			buffer_q <= buffer_d;
			abort_data_q <= abort_d;
			link_control_q <= link_d;
		end
	end

	// Read path, register update and identification checks
	a_id_read: assert property (@(posedge clk) disable iff (rst)
		(access && !write && addr == dp_map_pkg::addr_zero) |=>
		(rdata_q[dp_map_pkg::id_ver_lo +: 4] == arch_version && rdata_q[0]))
		else $error("ID read wrong");
	a_select_store: assert property (@(posedge clk) disable iff (rst)
		wr_select |=> (access_port_number == $past(wdata[31:24])))
		else $error("selection not stored");
	a_bank_width: assert property (@(posedge clk) disable iff (rst)
		!is_v2 |-> (debug_port_bank[3:1] == 3'b000))
		else $error("v1 bank too wide");
	a_scan_status_zero: assert property (@(posedge clk) disable iff (rst)
		(!serial_variant && rd_en && addr == dp_map_pkg::addr_bank
		&& bank_now == dp_map_pkg::bank_ctrl) |=> (rdata_q[7:6] == 2'b00))
		else $error("scan status not zero");
	a_serial_flags_ro: assert property (@(posedge clk) disable iff (rst)
		(serial_variant && err_q && !err_event) |=> err_q)
		else $error("serial flag cleared");
	a_resend_repeat: assert property (@(posedge clk) disable iff (rst)
		(serial_variant && rd_en && addr == dp_map_pkg::addr_select) |=>
		(rdata_q == $past(last_read_q)))
		else $error("resend mismatch");
	a_buffer_read: assert property (@(posedge clk) disable iff (rst)
		(rd_en && addr == dp_map_pkg::addr_buffer) |=> (rdata_q == $past(buffer_q)))
		else $error("buffer read mismatch");
	a_target_read: assert property (@(posedge clk) disable iff (rst)
		(is_v2 && rd_en && addr == dp_map_pkg::addr_bank
		&& bank_now == dp_map_pkg::bank_target) |=> (rdata_q == target_identification))
		else $error("target id wrong");
	a_id_fields: assert property (@(posedge clk) disable iff (rst)
		(rd_en && addr == dp_map_pkg::addr_zero) |=>
		(rdata_q[11:1] == designer_code && rdata_q[16] == minimal_config))
		else $error("ID fields wrong");

	// Upper identification fields follow the parameters
	a_id_upper: assert property (@(posedge clk) disable iff (rst)
		(rd_en && addr == dp_map_pkg::addr_zero) |=>
		(rdata_q[31:28] == revision && rdata_q[27:20] == part_number_field))
		else $error("ID upper fields wrong");

	// Reserved identification bits read zero
	a_id_reserved: assert property (@(posedge clk) disable iff (rst)
		(rd_en && addr == dp_map_pkg::addr_zero) |=>
		(rdata_q[19:17] == 3'b000))
		else $error("ID reserved bits set");

	// Abort strobe carries the written word
	a_abort_strobe: assert property (@(posedge clk) disable iff (rst)
		abort_write |=>
		(abort_data_q == $past(wdata)))
		else $error("abort data not stored");

	// Link control takes the written word
	a_link_store: assert property (@(posedge clk) disable iff (rst)
		wr_link |=>
		(link_control_q == $past(wdata)))
		else $error("link control not stored");

	// Bank 1 read returns link control
	a_link_read: assert property (@(posedge clk) disable iff (rst)
		(serial_variant && rd_en && addr == dp_map_pkg::addr_bank
		&& bank_now == dp_map_pkg::bank_link) |=> (rdata_q == $past(link_control_q)))
		else $error("link control read wrong");

	// Scan variant shows nothing in bank 1
	a_scan_link_zero: assert property (@(posedge clk) disable iff (rst)
		(!serial_variant && rd_en && addr == dp_map_pkg::addr_bank
		&& bank_now == dp_map_pkg::bank_link) |=> (rdata_q == 32'h0000_0000))
		else $error("scan link control not zero");

	// Bank 0 read returns control/status
	a_ctrl_read: assert property (@(posedge clk) disable iff (rst)
		(rd_en && addr == dp_map_pkg::addr_bank
		&& bank_now == dp_map_pkg::bank_ctrl) |=> (rdata_q == $past(ctrl_value)))
		else $error("control/status read wrong");

	// Bank 3 read returns protocol identification
	a_proto_read: assert property (@(posedge clk) disable iff (rst)
		(is_v2 && rd_en && addr == dp_map_pkg::addr_bank
		&& bank_now == dp_map_pkg::bank_proto) |=> (rdata_q == link_protocol_identification))
		else $error("protocol id wrong");

	// Port bank field taken from the selection write
	a_select_bank: assert property (@(posedge clk) disable iff (rst)
		wr_select |=>
		(access_port_bank == $past(wdata[7:4])))
		else $error("port bank not stored");

	// Scan variant clears a latched flag on a one
	a_scan_clear: assert property (@(posedge clk) disable iff (rst)
		(!serial_variant && w1c[2] && !err_event) |=>
		!err_q)
		else $error("scan flag not cleared");
endmodule

// file: core/dp_map_pkg.sv
// Shared constants for the debug port register map
package dp_map_pkg;
	// Register addresses, A[3:2] as a byte address
	localparam logic [3:0] addr_zero = 4'h0;
	localparam logic [3:0] addr_bank = 4'h4;
	localparam logic [3:0] addr_select = 4'h8;
	localparam logic [3:0] addr_buffer = 4'hc;
	// Debug port bank encodings
	localparam logic [3:0] bank_ctrl = 4'h0;
	localparam logic [3:0] bank_link = 4'h1;
	localparam logic [3:0] bank_target = 4'h2;
	localparam logic [3:0] bank_proto = 4'h3;
	// Selection register field positions
	localparam int sel_port_lo = 24;
	localparam int sel_apbank_lo = 4;
	// Control/status bit positions
	localparam int cs_orun = 1;
	localparam int cs_cmp = 4;
	localparam int cs_err = 5;
	localparam int cs_rdok = 6;
	localparam int cs_wderr = 7;
	// ID register field positions
	localparam int id_rev_lo = 28;
	localparam int id_part_lo = 20;
	localparam int id_min_bit = 16;
	localparam int id_ver_lo = 12;
	localparam int id_des_lo = 1;
	// Architecture version codes
	localparam logic [3:0] arch_v1 = 4'h1;
	localparam logic [3:0] arch_v2 = 4'h2;
	// Link control reset value
	localparam logic [31:0] link_ctrl_reset = 32'h0000_0000;
endpackage

// file: core/sticky_flag.sv
`timescale 1ns/1ps
// One latched status flag with set-over-clear priority
module sticky_flag (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Event and clear
	input wire logic set,
	input wire logic clear,
	// State
	output logic flag_q
);
	logic flag_d;

	// Set wins over a clear in the same cycle
	assign flag_d = set | (flag_q & ~clear);

	// Flag register
	always_ff @(posedge clk) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	a_set_wins: assert property (@(posedge clk) disable iff (rst) set |=> flag_q)
		else $error("flag lost an event");
endmodule

// file: verif/debug_probe_model.sv
`timescale 1ns/1ps
// Debugger probe model issuing one register access at a time
module debug_probe_model (
	// Clock
	input wire logic clk,
	// Access request
	output logic access,
	output logic write,
	output logic [3:0] addr,
	output logic [31:0] wdata,
	// Read answer
	input wire logic [31:0] rdata_q
);
	// Idle request lines from time zero
	initial begin
		access = 1'b0;
		write = 1'b0;
		addr = 4'h0;
		wdata = 32'h0000_0000;
	end

	// Request held for exactly one taking edge, then released
	task automatic issue(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		#1;
		access = 1'b1;
		write = wr;
		addr = a;
		wdata = d;
		@(posedge clk);
		#1;
		access = 1'b0;
		wdata = ~d; // Released data no longer shows the last value
	endtask

	// Register write; the word is sent exactly as given, reserved fields included
	// Any address may be sent; link control takes the word in the serial variant only
	task automatic write_reg(input logic [3:0] a, input logic [31:0] d);
		issue(1'b1, a, d);
	endtask

	// Register read; answer is settled one edge after the request
	task automatic read_reg(input logic [3:0] a, output logic [31:0] d);
		issue(1'b0, a, 32'h0000_0000);
		d = rdata_q;
	endtask
endmodule

// file: verif/debug_port_register_map_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the debug port register map
module debug_port_register_map_tb_top;
	logic clk, rst, access, write, ap_read_done, wd_err, rd_ok, err_ev, cmp_ev, orun_ev;
	logic [3:0] addr, ap_bank, dp_bank;
	logic [31:0] wdata, rdata_q, ap_data, abort_data_q, link_control_q, v;
	logic [7:0] port_num;
	logic abort_write;
	int failures = 0;
	int checked = 0;
	int aborts = 0;

	// Count abort strobes seen at the taking edge
	always @(posedge clk) begin
		if (abort_write === 1'b1) begin
			aborts++;
		end
	end

	// Design under test with serial, minimal, version 2 defaults
	dp_register_map dut (.clk(clk), .rst(rst), .access(access), .write(write), .addr(addr),
		.wdata(wdata), .rdata_q(rdata_q), .ap_read_done(ap_read_done),
		.ap_read_data(ap_data), .write_data_error_flag(wd_err), .read_success_flag(rd_ok),
		.err_event(err_ev), .cmp_event(cmp_ev), .orun_event(orun_ev),
		.access_port_number(port_num), .access_port_bank(ap_bank),
		.debug_port_bank(dp_bank), .abort_write(abort_write),
		.abort_data_q(abort_data_q), .link_control_q(link_control_q));

	// Debugger side
	debug_probe_model probe (.clk(clk), .access(access), .write(write), .addr(addr),
		.wdata(wdata), .rdata_q(rdata_q));

	// Clock at 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Value comparison with mismatch report
	task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		#100us;
		failures++;
		tally_and_finish();
	end

	// Test sequence
	initial begin
		rst = 1'b1;
		{ap_read_done, wd_err, rd_ok, err_ev, cmp_ev, orun_ev} = 6'h00;
		ap_data = 32'h0000_0000;
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		probe.write_reg(4'h8, 32'hab00_00f1);
		compare({24'h0, port_num}, 32'h0000_00ab);
		compare({28'h0, ap_bank}, 32'h0000_000f);
		compare({28'h0, dp_bank}, 32'h0000_0001);
		probe.read_reg(4'h0, v);
		compare(v, {4'h0, 8'h00, 3'h0, 1'b1, dp_map_pkg::arch_v2, 11'h000, 1'b1});
		probe.write_reg(4'h4, 32'h1234_5678);
		compare(link_control_q, 32'h1234_5678);
		probe.read_reg(4'h4, v);
		compare(v, 32'h1234_5678);
		probe.write_reg(4'h8, 32'h0000_0002);
		probe.read_reg(4'h4, v);
		compare(v, 32'h0000_0001);
		probe.write_reg(4'h8, 32'h0000_0003);
		probe.read_reg(4'h4, v);
		compare(v, 32'h0000_0001);
		// Status levels and one pulse of every latched event
		probe.write_reg(4'h8, 32'h0000_0000);
		@(posedge clk);
		#1;
		{wd_err, rd_ok, err_ev, cmp_ev, orun_ev} = 5'h1f;
		@(posedge clk);
		#1;
		{err_ev, cmp_ev, orun_ev} = 3'h0;
		probe.read_reg(4'h4, v);
		compare(v, 32'h0000_00e2);
		probe.write_reg(4'h4, 32'hff00_00e2);
		probe.read_reg(4'h4, v);
		compare(v, 32'h0000_00e2);
		// Port read result into the buffer, then resend
		@(posedge clk);
		#1;
		ap_read_done = 1'b1;
		ap_data = 32'hcafe_f00d;
		@(posedge clk);
		#1;
		ap_read_done = 1'b0;
		ap_data = 32'h3501_0ff2;
		probe.read_reg(4'hc, v);
		compare(v, 32'hcafe_f00d);
		probe.read_reg(4'h8, v);
		compare(v, 32'hcafe_f00d);
		probe.write_reg(4'h0, 32'h0000_001f);
		compare(abort_data_q, 32'h0000_001f);
		compare(aborts, 32'h0000_0001);
		tally_and_finish();
	end
endmodule
